/* File: src/sensor_spi_pkg.sv */
package sensor_spi_pkg;

  localparam int          WORD_W         = 16;
  localparam logic [3:0]  LAST_BIT       = 4'hF;
  localparam logic [2:0]  CODE_NOP       = 3'h1;
  localparam logic [2:0]  CODE_DIAG1     = 3'h2;
  localparam logic [2:0]  CODE_ONOFF     = 3'h3;
  localparam logic [2:0]  CODE_PROG      = 3'h5;
  localparam logic [2:0]  CODE_DIAG2     = 3'h6;
  localparam logic [15:0] NOP_WORD       = 16'h9101;
  localparam logic [15:0] ALL_ONES       = 16'hFFFF;
  localparam logic [11:0] DIAG_UPPER     = 12'h000;
  localparam logic [11:0] PROG_UPPER     = 12'h184;
  localparam logic [10:0] ONOFF_UPPER    = 11'h000;
  localparam logic [6:0]  PROG_ANS_UPPER = 7'h0C;
  localparam int          SEL_BIT        = 3;
  localparam int          ON_BIT         = 4;
  localparam int          PM_BIT         = 3;

  // Raw fault indications from the analog monitors, per channel except the shared overtemp
  typedef struct packed {
    logic       overtemp;
    logic [1:0] iout_high;
    logic [1:0] iout_low;
    logic [1:0] vout_high;
    logic [1:0] vret_high;
    logic [1:0] vout_low_off;
    logic [1:0] vout_high_off;
  } sense_t;

  // Latched diagnosis of one channel
  typedef struct packed {
    logic vret_high;
    logic vout_high;
    logic iout_low;
    logic iout_high;
  } latch_t;

  typedef enum logic {CH_OFF, CH_ON} ch_state_t;

endpackage : sensor_spi_pkg

/* File: src/spi_link.sv */
`timescale 1ns/100ps
module spi_link
  import sensor_spi_pkg::*;
(
  // Link pins
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              mosi,
  output logic                   miso,
  // Core side
  input  wire logic [WORD_W-1:0] answer,
  output logic [WORD_W-1:0]      cmd_word,
  output logic                   frame_done
);

  logic [3:0]        bit_cnt_reg;
  logic [WORD_W-1:0] tx_reg;

  // Receive on the falling edge; chip select clears the position
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 4'h0;
      frame_done  <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (bit_cnt_reg == LAST_BIT) begin
        frame_done <= 1'b1;
      end
    end
  end

  // Command data is kept after the frame so the core can take it
  always_ff @(negedge sclk) begin
    if (!cs_n) begin
      cmd_word <= {cmd_word[WORD_W-2:0], mosi};
    end
  end

  // Answer word is quasi-static while a frame runs
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      miso   <= 1'b0;
      tx_reg <= 16'h0000;
    end else if (bit_cnt_reg == 4'h0) begin
      miso   <= answer[WORD_W-1];
      tx_reg <= {answer[WORD_W-2:0], 1'b0};
    end else begin
      miso   <= tx_reg[WORD_W-1];
      tx_reg <= {tx_reg[WORD_W-2:0], 1'b0};
    end
  end

endmodule : spi_link

/* File: src/sensor_spi_core.sv */
`timescale 1ns/100ps
module sensor_spi_core (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  // Serial link
  input  wire logic                   sclk,
  input  wire logic                   cs_n,
  input  wire logic                   mosi,
  output logic                        miso,
  // Analog monitors and supplies
  input  wire sensor_spi_pkg::sense_t sense,
  input  wire logic                   vp_ok,
  // Channel and mode control
  output logic [1:0]                  chan_on,
  output logic                        prog_mode
);
  import sensor_spi_pkg::*;

  logic [WORD_W-1:0]  answer_reg;
  logic [WORD_W-1:0]  answer_next;
  logic [WORD_W-1:0]  cmd_word;
  logic               frame_done;
  logic [2:0]         done_sync_reg;
  logic               new_cmd;
  sense_t             sense_s1_reg;
  sense_t             sense_reg;
  logic [1:0]         vp_sync_reg;
  ch_state_t [1:0]    ch_reg;
  latch_t [1:0]       latch_reg;
  logic [1:0]         fault_now;
  logic [1:0]         onoff_hit;
  logic               is_nop;
  logic               is_diag1;
  logic               is_diag2;
  logic               is_onoff;
  logic               is_prog;
  logic               sel;

  spi_link u_link (
    .sclk       (sclk),
    .cs_n       (cs_n),
    .mosi       (mosi),
    .miso       (miso),
    .answer     (answer_reg),
    .cmd_word   (cmd_word),
    .frame_done (frame_done)
  );

  // Frame-complete level crosses by two flops, then an edge detect
  always_ff @(posedge core_clk) begin
    if (srst) begin
      done_sync_reg <= 3'h0;
    end else begin
      done_sync_reg <= {done_sync_reg[1:0], frame_done};
    end
  end
  assign new_cmd = done_sync_reg[1] & ~done_sync_reg[2];

  // Monitor pins and programming supply pass two flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sense_s1_reg <= '0;
      sense_reg    <= '0;
      vp_sync_reg  <= 2'h0;
    end else begin
      sense_s1_reg <= sense;
      sense_reg    <= sense_s1_reg;
      vp_sync_reg  <= {vp_sync_reg[0], vp_ok};
    end
  end

  assign sel      = cmd_word[SEL_BIT];
  assign is_nop   = cmd_word == NOP_WORD;
  assign is_diag1 = cmd_word[15:4] == DIAG_UPPER && cmd_word[2:0] == CODE_DIAG1;
  assign is_diag2 = cmd_word[15:4] == DIAG_UPPER && cmd_word[2:0] == CODE_DIAG2;
  assign is_onoff = cmd_word[15:5] == ONOFF_UPPER && cmd_word[2:0] == CODE_ONOFF;
  assign is_prog  = cmd_word[15:4] == PROG_UPPER && cmd_word[2:0] == CODE_PROG;

  // Per-channel fault latching and shutdown
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      latch_t raw;
      assign raw = '{vret_high: sense_reg.vret_high[ch],
                     vout_high: sense_reg.vout_high[ch],
                     iout_low:  sense_reg.iout_low[ch],
                     iout_high: sense_reg.iout_high[ch]};
      assign fault_now[ch] = (|raw) | sense_reg.overtemp;
      assign onoff_hit[ch] = new_cmd & is_onoff & (sel == 1'(ch));

      always_ff @(posedge core_clk) begin
        if (srst) begin
          ch_reg[ch] <= CH_OFF;
        end else if (ch_reg[ch] == CH_ON && fault_now[ch]) begin
          ch_reg[ch] <= CH_OFF;
        end else if (onoff_hit[ch]) begin
          ch_reg[ch] <= cmd_word[ON_BIT] ? CH_ON : CH_OFF;
        end
      end

      // Bits are set only while on, cleared by a power command in either state; the set wins over a same-cycle clear
      always_ff @(posedge core_clk) begin
        if (srst) begin
          latch_reg[ch] <= '0;
        end else if (ch_reg[ch] == CH_ON && (|raw)) begin
          latch_reg[ch] <= latch_reg[ch] | raw;
        end else if (onoff_hit[ch]) begin
          latch_reg[ch] <= '0;
        end
      end
    end
  endgenerate

  // Enables are the channel state flops themselves
  assign chan_on = {ch_reg[1] == CH_ON, ch_reg[0] == CH_ON};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prog_mode <= 1'b0;
    end else if (new_cmd && is_prog) begin
      prog_mode <= cmd_word[PM_BIT] & vp_sync_reg[1];
    end
  end

  always_comb begin
    answer_next = ALL_ONES;
    if (is_nop) begin
      answer_next = cmd_word;
    end else if ((is_diag1 || is_diag2) && prog_mode) begin
      answer_next = ALL_ONES;
    end else if (is_diag1) begin
      answer_next = {2'b00, ch_reg[sel] == CH_OFF, sense_reg.overtemp,
                     latch_reg[sel], cmd_word[7:0]};
    end else if (is_diag2) begin
      if (ch_reg[sel] == CH_ON) begin
        answer_next = {3'b000, sense_reg.overtemp, 4'h4, cmd_word[7:0]};
      end else begin
        answer_next = {3'b000, sense_reg.overtemp, 2'b00,
                       sense_reg.vout_high_off[sel],
                       sense_reg.vout_low_off[sel], cmd_word[7:0]};
      end
    end else if (is_onoff) begin
      answer_next = {8'h00, cmd_word[7:0]};
    end else if (is_prog) begin
      answer_next = {PROG_ANS_UPPER, cmd_word[PM_BIT] & vp_sync_reg[1],
                     cmd_word[7:0]};
    end
  end

  // Held until the next command arrives, then shifted in the next frame
  always_ff @(posedge core_clk) begin
    if (srst) begin
      answer_reg <= ALL_ONES;
    end else if (new_cmd) begin
      answer_reg <= answer_next;
    end
  end

  AST_NOP_ECHO: assert property (@(posedge core_clk) disable iff (srst)
    new_cmd && cmd_word == NOP_WORD |=> answer_reg == 16'h9101)
    else $error("poll command not echoed");

  AST_INVALID_ONES: assert property (@(posedge core_clk) disable iff (srst)
    new_cmd && cmd_word[2:0] == 3'h0 |=> answer_reg == 16'hFFFF)
    else $error("invalid command not answered with ones");

  AST_FAULT_OFF: assert property (@(posedge core_clk) disable iff (srst)
    chan_on[0] && fault_now[0]
    |=> !chan_on[0] ##1 (!chan_on[0] || $past(onoff_hit[0])))
    else $error("faulted channel 0 stayed on");

  AST_LATCH_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !onoff_hit[1] |=> (latch_reg[1] & $past(latch_reg[1])) == $past(latch_reg[1]))
    else $error("latched fault lost without power command");

  AST_DIAG_READ: assert property (@(posedge core_clk) disable iff (srst)
    new_cmd && cmd_word == 16'h0002 && !prog_mode
    |=> answer_reg[11:8] == $past(latch_reg[0]))
    else $error("diagnosis answer does not show latch");

  AST_LOW_BYTE: assert property (@(posedge core_clk) disable iff (srst)
    new_cmd && cmd_word[15:4] == 12'h000 && cmd_word[2:0] == 3'h3
    |=> answer_reg[7:0] == $past(cmd_word[7:0]) && answer_reg[15:8] == 8'h00)
    else $error("low byte not reflected");

  AST_PM_DIAG: assert property (@(posedge core_clk) disable iff (srst)
    new_cmd && prog_mode && cmd_word[15:3] == 13'h0000 && cmd_word[1:0] == 2'h2
    |=> answer_reg == 16'hFFFF)
    else $error("diagnosis in programming mode not refused");

  AST_ANSWER_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !new_cmd |=> $stable(answer_reg))
    else $error("answer changed without a new command");

  AST_POWER_ON: assert property (@(posedge core_clk) disable iff (srst)
    onoff_hit[0] && cmd_word[4] && !fault_now[0] |=> chan_on[0] && latch_reg[0] == 4'h0)
    else $error("power command did not clear and enable");

  COV_NOP:     cover property (@(posedge core_clk) new_cmd && is_nop);
  COV_INVALID: cover property (@(posedge core_clk) new_cmd && answer_next == ALL_ONES);
  COV_FAULT:   cover property (@(posedge core_clk) chan_on[1] && fault_now[1]);
  COV_DIAG:    cover property (@(posedge core_clk) new_cmd && is_diag1 && |latch_reg[0]);

endmodule : sensor_spi_core

/* File: sim/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model
  import sensor_spi_pkg::*;
(
  // Link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Mode 1 frame, 80 ns bit time: drive on rising, sample on falling
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    // Keeps the link edges off the core clock edges
    #7;
    cs_n = 1'b0;
    #40;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b1;
      mosi = w[i];
      #40;
      sclk = 1'b0;
      r[i] = miso;
      #40;
    end
    // Hold select so the completed word can cross to the core
    #100;
    cs_n = 1'b1;
    // Released data line must not keep showing the last bit
    mosi = ~mosi;
    #200;
  endtask : xfer

  // Collects the answer to the previous frame
  task automatic poll(output logic [15:0] r);
    xfer(NOP_WORD, r);
  endtask : poll
endmodule : spi_host_model

/* File: sim/tb_sensor_spi_core.sv */
`timescale 1ns/100ps
module tb_sensor_spi_core;
  import sensor_spi_pkg::*;
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] ans;
  } row_t;
  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  wire logic   sclk;
  wire logic   cs_n;
  wire logic   mosi;
  logic        miso;
  sense_t      sense    = '0;
  sense_t      s;
  logic        vp_ok    = 1'b1;
  logic [1:0]  chan_on;
  logic        prog_mode;
  logic [15:0] r;
  int          num_errors = 0;
  int          n_checks   = 0;
  int          cycles     = 0;
  row_t        rows [11] = '{
    '{16'h9101, 16'h9101}, '{16'h0000, 16'hFFFF}, '{16'h0007, 16'hFFFF},
    '{16'h0004, 16'hFFFF}, '{16'h0001, 16'hFFFF}, '{16'h0003, 16'h0003},
    '{16'h0013, 16'h0013}, '{16'h001B, 16'h001B}, '{16'h0002, 16'h0002},
    '{16'h000A, 16'h000A}, '{16'h0006, 16'h0406}};

  always #10 core_clk = ~core_clk;

  sensor_spi_core uut (.core_clk(core_clk), .srst(srst), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .sense(sense), .vp_ok(vp_ok),
    .chan_on(chan_on), .prog_mode(prog_mode));
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_ans(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk_ans

  task automatic chk_lvl(input logic [2:0] e);
    n_checks++;
    if ({prog_mode, chan_on} !== e) begin
      num_errors++;
      $display("BAD prog_mode,chan_on exp %b got %b", e, {prog_mode, chan_on});
    end
  endtask : chk_lvl

  // Command frame, then a poll frame that brings its answer back
  task automatic run(input logic [15:0] c, input logic [15:0] e);
    host.xfer(c, r);
    chk_ans("poll echo", NOP_WORD, r);
    host.poll(r);
    chk_ans("answer", e, r);
  endtask : run

  task automatic set_in(input sense_t sv, input logic v);
    @(posedge core_clk);
    sense <= sv;
    vp_ok <= v;
    repeat (10) @(posedge core_clk);
  endtask : set_in

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk_lvl(3'b000);
    host.poll(r);
    chk_ans("reset answer", ALL_ONES, r);
    foreach (rows[i]) begin
      run(rows[i].cmd, rows[i].ans);
    end
    chk_lvl(3'b011);
    s = '0;
    s.iout_high = 2'b01;
    set_in(s, 1'b1);
    chk_lvl(3'b010);
    set_in('0, 1'b1);
    run(16'h0002, 16'h2102);
    run(16'h0006, 16'h0006);
    run(16'h0002, 16'h2102);
    run(16'h0013, 16'h0013);
    run(16'h0002, 16'h0002);
    s = '0;
    s.overtemp = 1'b1;
    set_in(s, 1'b1);
    chk_lvl(3'b000);
    run(16'h000E, 16'h100E);
    set_in('0, 1'b1);
    run(16'h184D, 16'h194D);
    chk_lvl(3'b100);
    run(16'h0002, ALL_ONES);
    run(16'h0006, ALL_ONES);
    run(16'h1845, 16'h1845);
    set_in('0, 1'b0);
    run(16'h184D, 16'h184D);
    chk_lvl(3'b000);
    // Reset in mid-run with a channel on
    run(16'h0013, 16'h0013);
    chk_lvl(3'b001);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk_lvl(3'b000);
    host.poll(r);
    chk_ans("mid reset answer", ALL_ONES, r);
    tally_and_finish();
  end
endmodule : tb_sensor_spi_core
